/* File: src/acr_pkg.sv */
// Constants, codes and carrier types of the converter control register bank
package acr_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_PORT_CFG   = 8'h00;
  localparam logic [7:0] ADDR_CHAN_INDEX = 8'h10;
  localparam logic [7:0] ADDR_POWER      = 8'h25;
  localparam logic [7:0] ADDR_SKEW       = 8'h70;
  localparam logic [7:0] ADDR_SLIP       = 8'h71;
  localparam logic [7:0] ADDR_DIVISOR    = 8'h72;
  localparam logic [7:0] ADDR_OUT_A      = 8'h73;
  localparam logic [7:0] ADDR_OUT_B      = 8'h74;
  localparam logic [7:0] ADDR_STATUS     = 8'h75;
  localparam logic [7:0] ADDR_TEST_CTRL  = 8'hC0;
  localparam logic [7:0] ADDR_USER1_LO   = 8'hC2;
  localparam logic [7:0] ADDR_USER1_HI   = 8'hC3;
  localparam logic [7:0] ADDR_USER2_LO   = 8'hC4;
  localparam logic [7:0] ADDR_USER2_HI   = 8'hC5;

  // Field positions
  localparam int SOFT_RESET_BIT = 5;
  localparam int DLL_RANGE_BIT  = 6;
  localparam int DDR_EN_BIT     = 4;
  localparam int DRIVE_LSB      = 5;
  localparam int TMODE_LSB      = 6;

  // Reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // One-hot control field codes shared by power, divider, drive and coding
  localparam logic [2:0] CODE_PIN = 3'h0;
  localparam logic [2:0] CODE_A   = 3'h1;
  localparam logic [2:0] CODE_B   = 3'h2;
  localparam logic [2:0] CODE_C   = 3'h4;

  // Tri-level pin levels as seen by the logic
  localparam logic [1:0] PIN_LOW  = 2'h0;
  localparam logic [1:0] PIN_MID  = 2'h1;
  localparam logic [1:0] PIN_HIGH = 2'h2;

  // Fixed test words
  localparam logic [15:0] WORD_MID   = 16'h8000;
  localparam logic [15:0] WORD_ONES  = 16'hFFFF;
  localparam logic [15:0] WORD_ZEROS = 16'h0000;
  localparam logic [15:0] WORD_CHK_A = 16'hAAAA;
  localparam logic [15:0] WORD_CHK_B = 16'h5555;

  // Test pattern selector
  typedef enum logic [3:0] {
    PAT_OFF   = 4'h0,
    PAT_MID   = 4'h1,
    PAT_POS   = 4'h2,
    PAT_NEG   = 4'h3,
    PAT_CHECK = 4'h4,
    PAT_RSV5  = 4'h5,
    PAT_RSV6  = 4'h6,
    PAT_ONEZ  = 4'h7,
    PAT_USER  = 4'h8
  } acr_pattern_t;

  // Decoded modes
  typedef enum logic [1:0] {
    PWR_NORMAL = 2'h0,
    PWR_NAP    = 2'h1,
    PWR_SLEEP  = 2'h2
  } acr_power_t;

  typedef enum logic [1:0] {
    DRV_LVDS_2MA = 2'h0,
    DRV_LVDS_3MA = 2'h1,
    DRV_LVCMOS   = 2'h2
  } acr_drive_t;

  typedef enum logic [1:0] {
    FMT_TWOS   = 2'h0,
    FMT_GRAY   = 2'h1,
    FMT_BINARY = 2'h2
  } acr_coding_t;

  // Register access request from the serial port front end
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } acr_req_t;

  // Effective settings handed to the converter and output stages
  typedef struct packed {
    acr_power_t  power0;
    acr_power_t  power1;
    acr_drive_t  drive;
    acr_coding_t coding;
    logic        ddr_en;
    logic        dll_fast;
    logic [7:0]  skew;
  } acr_cfg_t;

endpackage

/* File: src/acr_regs.sv */
// Converter control register bank: modes, divider, output setup and test patterns
`timescale 1ns/1ps
`default_nettype none

module acr_regs
  import acr_pkg::*;
#(
  parameter int NUM_CONV  = 2,  // Converter cores behind the index register
  parameter int MAX_DIV   = 4   // Largest clock divisor supported
) (
  input  wire logic        mclk,            // Sample clock, 25 MHz
  input  wire logic        rst_n,           // Asynchronous reset, active low
  input  wire acr_req_t    req,             // Register read or write request
  output logic [7:0]       rd_data,         // Read data, one cycle after rd
  output logic             rd_valid,        // Read data qualifier
  input  wire logic [1:0]  power_mode_pin,  // Tri-level power pin
  input  wire logic [1:0]  divisor_select_pin, // Tri-level divider pin
  input  wire logic [1:0]  output_drive_pin,   // Tri-level output mode pin
  input  wire logic [1:0]  output_coding_pin,  // Tri-level output coding pin
  output acr_cfg_t         cfg,             // Effective settings
  output logic [2:0]       divisor,         // Effective divisor 1, 2 or 4
  output logic             div_tick,        // Rising edge of divided clock
  output logic             test_active,     // Test pattern replaces data
  output logic [15:0]      test_word        // Test word on the output bus
);

  // Elaboration checks: the index bits and the divider serve these sizes only
  if (NUM_CONV != 2) begin : g_bad_conv
    $error("acr_regs serves exactly two converters");
  end
  if (MAX_DIV != 4) begin : g_bad_div
    $error("acr_regs divider serves divisor 4 at most");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register storage
  // Fields live here as written; decoding happens further down
  logic [7:0]  port_cfg_q;        // Port configuration
  logic [1:0]  chan_index_q;      // One bit per converter
  logic [2:0]  power_q [2];       // Per converter power field
  logic [7:0]  skew_q;            // Core skew trim
  logic [2:0]  divisor_q;         // Divider field
  logic [7:0]  out_a_q;           // Drive and coding fields
  logic [7:0]  out_b_q;           // Last value written to DDR control
  logic [7:0]  status_q;          // Live DLL and DDR state
  logic [7:0]  test_ctrl_q;       // Test mode and pattern
  logic [15:0] user1_q;           // First user word
  logic [15:0] user2_q;           // Second user word
  logic        soft_rst;          // Soft reset request this cycle
  logic        wr_hit;            // Write strobe qualifier

  // Every write is taken at once; the front end inserts no wait states
  assign wr_hit   = req.wr;
  // Address decode is exact; no offset is aliased onto another
  // Self-clearing bit: a write with it set is the reset itself
  assign soft_rst = wr_hit && (req.addr == ADDR_PORT_CFG) && req.wdata[SOFT_RESET_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Port configuration, soft reset bit never stored
  // Only the soft reset bit acts; the other bits are kept for read back
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      port_cfg_q <= RESET_BYTE;
    end else if (soft_rst) begin
      port_cfg_q <= RESET_BYTE;
    end else if (wr_hit && req.addr == ADDR_PORT_CFG) begin
      port_cfg_q <= req.wdata;
    end
  end

  // Channel index, defaults to no converter addressed
  // Both bits set would address both cores; the host must not do that
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      chan_index_q <= RESET_BYTE[1:0];
    end else if (soft_rst) begin
      chan_index_q <= RESET_BYTE[1:0];
    end else if (wr_hit && req.addr == ADDR_CHAN_INDEX) begin
      chan_index_q <= req.wdata[1:0];
    end
  end

  // Per converter power field, written only where the index points
  // Left out of the soft reset so a running system keeps its power state
  // One field per core, picked through the index bits
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_power
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          power_q[gi] <= CODE_PIN;
        end else if (wr_hit && req.addr == ADDR_POWER && chan_index_q[gi]) begin
          power_q[gi] <= req.wdata[2:0];
        end
        // Soft reset deliberately absent here
      end
    end
  endgenerate

  // Skew trim
  // The trim reaches the cores one cycle later through cfg
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      skew_q <= RESET_BYTE;
    end else if (soft_rst) begin
      skew_q <= RESET_BYTE;
    end else if (wr_hit && req.addr == ADDR_SKEW) begin
      skew_q <= req.wdata;
    end
  end

  // Divider and output mode fields survive soft reset
  // A new divisor acts at once; the counter wraps at the new end count
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      divisor_q <= CODE_PIN;
      out_a_q   <= RESET_BYTE;
    end else begin
      if (wr_hit && req.addr == ADDR_DIVISOR) begin
        divisor_q <= req.wdata[2:0];
      end
      if (wr_hit && req.addr == ADDR_OUT_A) begin
        out_a_q <= req.wdata;
      end
    end
  end

  // DDR control: the written word folds into the live state by XOR, so a
  // host writing (B ^ status ^ wanted) leaves status equal to wanted
  // Bit 6 picks the DLL range and bit 4 turns on double data rate
  // Writes to the status offset itself are ignored
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      out_b_q  <= RESET_BYTE;
      status_q <= RESET_BYTE;
    end else if (soft_rst) begin
      out_b_q  <= RESET_BYTE;
      status_q <= RESET_BYTE;
    end else if (wr_hit && req.addr == ADDR_OUT_B) begin
      out_b_q  <= req.wdata;
      status_q <= req.wdata ^ out_b_q ^ status_q;
    end
  end

  // Test control and user words
  // User bytes are independent, so a word shows a mix while rewritten
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      test_ctrl_q <= RESET_BYTE;
      user1_q     <= {RESET_BYTE, RESET_BYTE};
      user2_q     <= {RESET_BYTE, RESET_BYTE};
    end else if (soft_rst) begin
      test_ctrl_q <= RESET_BYTE;
      user1_q     <= {RESET_BYTE, RESET_BYTE};
      user2_q     <= {RESET_BYTE, RESET_BYTE};
    end else if (wr_hit) begin
      unique case (req.addr)
        ADDR_TEST_CTRL: test_ctrl_q    <= req.wdata;
        ADDR_USER1_LO:  user1_q[7:0]   <= req.wdata;
        ADDR_USER1_HI:  user1_q[15:8]  <= req.wdata;
        ADDR_USER2_LO:  user2_q[7:0]   <= req.wdata;
        ADDR_USER2_HI:  user2_q[15:8]  <= req.wdata;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field decode: a legal register code wins, 000 or a reserved code falls
  // back to the pin so the outputs never sit in an undefined mode
  // Pin level three is not a legal tri-level state and reads as low
  function automatic logic [1:0] pick(input logic [2:0] code, input logic [1:0] pin);
    logic [1:0] sel;
    sel = (pin == PIN_HIGH) ? 2'h2 : ((pin == PIN_MID) ? 2'h1 : 2'h0);
    unique case (code)
      CODE_A:  pick = 2'h0;
      CODE_B:  pick = 2'h1;
      CODE_C:  pick = 2'h2;
      default: pick = sel;
    endcase
  endfunction

  logic [1:0] div_sel;  // 0 divide 1, 1 divide 2, 2 divide 4

  // Effective settings, registered so the outputs come from flip-flops
  // One cycle of latency buys glitch-free outputs; reserved codes never
  // reach the enums, so every output names a legal mode
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= '0;
    end else begin
      cfg.power0   <= acr_power_t'(pick(power_q[0], power_mode_pin));
      cfg.power1   <= acr_power_t'(pick(power_q[1], power_mode_pin));
      cfg.drive    <= acr_drive_t'(pick(out_a_q[DRIVE_LSB +: 3], output_drive_pin));
      cfg.coding   <= acr_coding_t'(pick(out_a_q[2:0], output_coding_pin));
      cfg.ddr_en   <= status_q[DDR_EN_BIT];
      cfg.dll_fast <= status_q[DLL_RANGE_BIT];
      cfg.skew     <= skew_q;
    end
  end

  // Combinational so the counter compares against the current end count
  assign div_sel = pick(divisor_q, divisor_select_pin);

  ////////////////////////////////////////////////////////////////////////////
  // Clock divider with phase slip; a slip adds one extra count so the next
  // rising edge of the divided clock comes one input cycle early
  // The counter runs from zero to divisor minus one and ticks as it wraps;
  // divide by one ticks every cycle, so a slip there has nothing to advance
  logic [1:0] div_cnt_q;   // Phase within the divided period
  logic [2:0] div_last;    // Divisor minus one
  logic       slip_req;    // Write to slip register

  assign slip_req = wr_hit && (req.addr == ADDR_SLIP);
  assign div_last = (3'h1 << div_sel) - 3'h1;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_q <= 2'h0;
      div_tick  <= 1'b0;
      divisor   <= 3'h1;
    end else begin
      divisor <= 3'h1 << div_sel;
      // Divisor output follows the decoded field one cycle later
      if ({1'b0, div_cnt_q} >= div_last) begin
        // A slip on the edge cycle starts the next period one count in
        div_cnt_q <= slip_req ? 2'h1 : 2'h0;
        div_tick  <= 1'b1;
      end else if (slip_req && {1'b0, div_cnt_q} + 3'h1 >= div_last) begin
        // Skip the last count: edge advances one cycle
        div_cnt_q <= 2'h0;
        div_tick  <= 1'b1;
      end else begin
        div_cnt_q <= div_cnt_q + (slip_req ? 2'h2 : 2'h1);
        div_tick  <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Test pattern generator; alternation steps on the divided clock so each
  // output sample sees one word
  // Single word patterns and reserved modes stay static on the first word
  logic [15:0] word1;      // First pattern word
  logic [15:0] word2;      // Second pattern word
  logic        two_words;  // Pattern has a second word
  logic        pat_on;     // Pattern selected
  logic        phase_q;    // Which word is on the bus

  // Default to pattern on with zero words; each selection overrides what it uses
  always_comb begin
    word1     = WORD_ZEROS;
    word2     = WORD_ZEROS;
    two_words = 1'b0;
    pat_on    = 1'b1;
    unique case (test_ctrl_q[3:0])
      PAT_MID:   word1 = WORD_MID;
      PAT_POS:   word1 = WORD_ONES;
      PAT_NEG:   word1 = WORD_ZEROS;
      PAT_CHECK: begin
        word1     = WORD_CHK_A;
        word2     = WORD_CHK_B;
        two_words = 1'b1;
      end
      PAT_ONEZ: begin
        word1     = WORD_ONES;
        word2     = WORD_ZEROS;
        two_words = 1'b1;
      end
      PAT_USER: begin
        word1     = user1_q;
        word2     = user2_q;
        two_words = 1'b1;
      end
      // Off and reserved selections leave live data on the bus
      default:   pat_on = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q     <= 1'b0;
      test_active <= 1'b0;
      test_word   <= WORD_ZEROS;
    end else begin
      // Registered so the bus never sees decode glitches
      test_active <= pat_on;
      // Alternate only in mode 01; reserved modes stay static
      if (pat_on && two_words && test_ctrl_q[TMODE_LSB +: 2] == 2'h1) begin
        if (div_tick) begin
          phase_q <= ~phase_q;
        end
        test_word <= phase_q ? word2 : word1;
      end else begin
        phase_q   <= 1'b0;
        test_word <= pat_on ? word1 : WORD_ZEROS;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path, one cycle latency; unmapped addresses read zero
  // Data is captured only on a read so it holds until the next one
  logic [7:0] rd_mux;
  logic [2:0] power_rd;    // Field of the indexed converter

  always_comb begin
    // Power read shows the indexed core, or pin control when none is
    power_rd = chan_index_q[0] ? power_q[0] : (chan_index_q[1] ? power_q[1] : CODE_PIN);
    unique case (req.addr)
      ADDR_PORT_CFG:   rd_mux = port_cfg_q;
      ADDR_CHAN_INDEX: rd_mux = {6'h00, chan_index_q};
      ADDR_POWER:      rd_mux = {5'h00, power_rd};
      ADDR_SKEW:       rd_mux = skew_q;
      ADDR_DIVISOR:    rd_mux = {5'h00, divisor_q};
      ADDR_OUT_A:      rd_mux = out_a_q;
      ADDR_OUT_B:      rd_mux = out_b_q;
      ADDR_STATUS:     rd_mux = status_q;
      ADDR_TEST_CTRL:  rd_mux = test_ctrl_q;
      ADDR_USER1_LO:   rd_mux = user1_q[7:0];
      ADDR_USER1_HI:   rd_mux = user1_q[15:8];
      ADDR_USER2_LO:   rd_mux = user2_q[7:0];
      ADDR_USER2_HI:   rd_mux = user2_q[15:8];
      default:         rd_mux = RESET_BYTE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data  <= RESET_BYTE;
      rd_valid <= 1'b0;
    end else begin
      // One valid pulse pairs with each read strobe
      rd_valid <= req.rd;
      if (req.rd) begin
        rd_data <= rd_mux;
      end
    end
  end

endmodule

`default_nettype wire

/* File: test/acr_regs_props.sv */
// Property checker bound to the converter control register bank
`timescale 1ns/1ps
`default_nettype none
module acr_regs_checker
  import acr_pkg::*;
#(
  parameter int NUM_CONV = 2,  // Converter cores behind the index
  parameter int MAX_DIV  = 4   // Largest divisor
) (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire acr_req_t    req,
  input wire logic [7:0]  rd_data,
  input wire logic        rd_valid,
  input wire logic [1:0]  power_mode_pin,
  input wire logic [1:0]  divisor_select_pin,
  input wire logic [1:0]  output_drive_pin,
  input wire logic [1:0]  output_coding_pin,
  input wire acr_cfg_t    cfg,
  input wire logic [2:0]  divisor,
  input wire logic        div_tick,
  input wire logic        test_active,
  input wire logic [15:0] test_word
);
  // One clock domain, so clocking and reset are given once
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////
  // Register port timing
  a_read_answer: assert property (req.rd |=> rd_valid)
    else $error("read strobe without answer");
  a_no_stray_valid: assert property (!req.rd |=> !rd_valid)
    else $error("answer without read strobe");
  a_skew_lands: assert property (req.wr && req.addr == ADDR_SKEW
    |-> ##2 cfg.skew == $past(req.wdata, 2))
    else $error("skew write did not reach output");

  ////////////////////////////////////////////////////////////////////////
  // Divider behaviour; codes equal the divisor they select
  a_div_legal: assert property (divisor inside {3'h1, 3'h2, 3'h4})
    else $error("divisor outside 1, 2, 4");
  a_div_write: assert property (req.wr && req.addr == ADDR_DIVISOR
    && req.wdata[2:0] inside {3'h1, 3'h2, 3'h4}
    |-> ##2 {5'h00, divisor} == ($past(req.wdata, 2) & 8'h07))
    else $error("divisor write not applied");
  // At divisor 4 divided edges are never on adjacent cycles and never more than four cycles apart
  a_tick_min: assert property (div_tick && divisor == 3'h4 ##1 divisor == 3'h4
    |-> !div_tick)
    else $error("divided edges too close");
  a_tick_max: assert property (div_tick && divisor == 3'h4 ##1 divisor == 3'h4 [*4]
    |-> div_tick || $past(div_tick) || $past(div_tick, 2) || $past(div_tick, 3))
    else $error("divided edge missing");

  ////////////////////////////////////////////////////////////////////////
  // Test bus is quiet while no pattern is selected
  a_test_quiet: assert property (!test_active |-> test_word == 16'h0000)
    else $error("test word while inactive");

  c_div4: cover property (div_tick && divisor == 3'h4);
  c_alt: cover property (test_active && test_word == WORD_CHK_B);
  c_read: cover property (rd_valid && rd_data == 8'hFF);
endmodule

bind acr_regs acr_regs_checker #(.NUM_CONV(NUM_CONV), .MAX_DIV(MAX_DIV)) u_chk (
  .mclk(mclk), .rst_n(rst_n), .req(req), .rd_data(rd_data), .rd_valid(rd_valid),
  .power_mode_pin(power_mode_pin), .divisor_select_pin(divisor_select_pin),
  .output_drive_pin(output_drive_pin), .output_coding_pin(output_coding_pin),
  .cfg(cfg), .divisor(divisor), .div_tick(div_tick), .test_active(test_active),
  .test_word(test_word)
);
`default_nettype wire

/* File: test/acr_host_model.sv */
// Serial host stand-in that issues register requests to the bank
`timescale 1ns/1ps
`default_nettype none
module acr_host_model
  import acr_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_valid,
  output acr_req_t        req
);
  initial req = '0;

  // One write strobe; released fields show inverted junk, not old values
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  // Read strobe; the answer stands for one cycle after the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge mclk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h5A};
    @(posedge mclk);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hA5};
    #1;
    d = rd_data;
    v = rd_valid;
  endtask

  // DDR control update: old value xor status, then xor the wanted value
  task automatic upd_b(input logic [7:0] want);
    logic [7:0] b;
    logic [7:0] s;
    logic       v;
    rd(ADDR_OUT_B, b, v);
    rd(ADDR_STATUS, s, v);
    wr(ADDR_OUT_B, b ^ s ^ want);
  endtask
endmodule
`default_nettype wire

/* File: test/tb.sv */
// Self-checking testbench for the converter control register bank
`timescale 1ns/1ps
`default_nettype none
module tb
  import acr_pkg::*;
;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  acr_req_t    req;
  logic [7:0]  rd_data;
  logic        rd_valid;
  logic [1:0]  power_mode_pin = 2'h0;
  logic [1:0]  divisor_select_pin = 2'h0;
  logic [1:0]  output_drive_pin = 2'h0;
  logic [1:0]  output_coding_pin = 2'h0;
  acr_cfg_t    cfg;
  logic [2:0]  divisor;
  logic        div_tick;
  logic        test_active;
  logic [15:0] test_word;
  int          failures = 0;
  int          checks = 0;
  int          cycles = 0;
  logic [7:0]  rdv;
  logic        vld;

  initial forever #20 mclk = ~mclk;

  acr_regs DUT (.mclk(mclk), .rst_n(rst_n), .req(req), .rd_data(rd_data), .rd_valid(rd_valid),
    .power_mode_pin(power_mode_pin), .divisor_select_pin(divisor_select_pin),
    .output_drive_pin(output_drive_pin), .output_coding_pin(output_coding_pin), .cfg(cfg),
    .divisor(divisor), .div_tick(div_tick), .test_active(test_active), .test_word(test_word));
  acr_host_model HOST (.mclk(mclk), .rd_data(rd_data), .rd_valid(rd_valid), .req(req));

  ////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Write lands after register and output flop; two spare cycles
  task automatic settle;
    repeat (3) @(posedge mclk);
    #1;
  endtask
  task automatic rdck(input logic [7:0] a, input logic [7:0] e);
    HOST.rd(a, rdv, vld);
    chk({15'h0000, vld}, 16'h0001);
    chk({8'h00, rdv}, {8'h00, e});
  endtask
  task automatic set_pins(input logic [1:0] lv);
    @(posedge mclk);
    power_mode_pin <= lv;
    divisor_select_pin <= lv;
    output_drive_pin <= lv;
    output_coding_pin <= lv;
    settle;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset;
    chk({13'h0000, divisor}, 16'h0001);
    rdck(ADDR_SKEW, 8'h00);
    rdck(ADDR_CHAN_INDEX, 8'h00);
    $display("t_reset done");
  endtask

  // Every field left at zero follows its pin; power follows it on both cores
  task automatic t_pins;
    for (int lv = 2; lv >= 0; lv--) begin
      set_pins(2'(lv));
      chk({13'h0000, divisor}, 16'(1 << lv));
      chk({12'h000, cfg.power0, cfg.power1}, 16'(lv * 5));
      chk({12'h000, cfg.drive, cfg.coding}, 16'(lv * 5));
    end
    $display("t_pins done");
  endtask

  task automatic t_fields;
    HOST.wr(ADDR_POWER, 8'h02);            // No converter indexed yet
    settle;
    chk({14'h0000, cfg.power0}, 16'h0000);
    HOST.wr(ADDR_CHAN_INDEX, 8'h01);
    for (int i = 0; i < 3; i++) begin
      HOST.wr(ADDR_POWER, 8'(1 << i));
      HOST.wr(ADDR_DIVISOR, 8'(1 << i));
      HOST.wr(ADDR_OUT_A, 8'((1 << i) * 33));
      settle;
      chk({12'h000, cfg.power0, cfg.power1}, 16'(i * 4));
      chk({13'h0000, divisor}, 16'(1 << i));
      chk({12'h000, cfg.drive, cfg.coding}, 16'(i * 5));
    end
    // Reserved codes fall back to the pins, here at their high level
    set_pins(2'h2);
    HOST.wr(ADDR_POWER, 8'h03);
    HOST.wr(ADDR_DIVISOR, 8'h03);
    HOST.wr(ADDR_OUT_A, 8'h63);
    settle;
    chk({12'h000, cfg.power0, cfg.power1}, 16'h000A);
    chk({13'h0000, divisor}, 16'h0004);
    chk({12'h000, cfg.drive, cfg.coding}, 16'h000A);
    set_pins(2'h0);
    $display("t_fields done");
  endtask

  task automatic t_soft;
    HOST.wr(ADDR_SKEW, 8'hFF);
    HOST.wr(ADDR_DIVISOR, 8'h04);
    HOST.wr(ADDR_OUT_A, 8'h22);
    HOST.wr(ADDR_POWER, 8'h02);
    HOST.wr(ADDR_USER1_LO, 8'h77);
    rdck(ADDR_SKEW, 8'hFF);
    HOST.wr(ADDR_PORT_CFG, 8'h20);
    settle;
    chk({8'h00, cfg.skew}, 16'h0000);
    rdck(ADDR_USER1_LO, 8'h00);
    rdck(ADDR_CHAN_INDEX, 8'h00);
    chk({13'h0000, divisor}, 16'h0004);
    chk({12'h000, cfg.drive, cfg.coding}, 16'h0001);
    chk({12'h000, cfg.power0, cfg.power1}, 16'h0004);
    HOST.wr(ADDR_CHAN_INDEX, 8'h01);                   // Index was cleared
    rdck(ADDR_POWER, 8'h02);
    $display("t_soft done");
  endtask

  task automatic t_ddr;
    HOST.upd_b(8'h10);
    settle;
    chk({14'h0000, cfg.dll_fast, cfg.ddr_en}, 16'h0001);
    HOST.upd_b(8'h40);
    settle;
    chk({14'h0000, cfg.dll_fast, cfg.ddr_en}, 16'h0002);
    HOST.wr(ADDR_STATUS, 8'h10);           // Status is not writable
    settle;
    chk({14'h0000, cfg.dll_fast, cfg.ddr_en}, 16'h0002);
    HOST.rd(ADDR_STATUS, rdv, vld);
    chk({8'h00, rdv & 8'h50}, 16'h0040);
    $display("t_ddr done");
  endtask

  task automatic t_pattern;
    logic [15:0] ew [9] = '{16'h0000, WORD_MID, WORD_ONES, WORD_ZEROS, WORD_CHK_A,
                            16'h0000, 16'h0000, WORD_ONES, 16'h1234};
    logic [15:0] w2 [3] = '{WORD_CHK_B, WORD_ZEROS, 16'h5678};
    int          ac [3] = '{4, 7, 8};
    int          n1;
    int          n2;
    HOST.wr(ADDR_USER1_LO, 8'h34);
    HOST.wr(ADDR_USER1_HI, 8'h12);
    HOST.wr(ADDR_USER2_LO, 8'h78);
    HOST.wr(ADDR_USER2_HI, 8'h56);
    for (int c = 0; c < 9; c++) begin
      HOST.wr(ADDR_TEST_CTRL, 8'(c));
      settle;
      chk(test_word, ew[c]);
      chk({15'h0000, test_active}, 16'(9'h19E >> c) & 16'h0001);
    end
    // Alternating mode: only the two words of the pair, both seen
    for (int k = 0; k < 3; k++) begin
      HOST.wr(ADDR_TEST_CTRL, 8'h40 | 8'(ac[k]));
      settle;
      n1 = 0;
      n2 = 0;
      repeat (12) begin
        @(posedge mclk);
        #1;
        n1 += int'(test_word === ew[ac[k]]);
        n2 += int'(test_word === w2[k]);
      end
      chk(16'(n1 + n2), 16'h000C);
      chk(16'(n1 > 0 && n2 > 0), 16'h0001);
    end
    HOST.wr(ADDR_TEST_CTRL, 8'h00);
    $display("t_pattern done");
  endtask

  // Three divide-by-four periods span 12 cycles; a slip makes it 11, also
  // when the slip lands on the very cycle of a divided edge
  task automatic t_slip;
    int n;
    int k;
    for (int lead = 0; lead <= 2; lead += 2) begin
      for (n = 0; n < 20 && div_tick !== 1'b1; n++) begin
        @(posedge mclk);
        #1;
      end
      n = 0;
      k = 0;
      fork
        begin
          repeat (lead) @(posedge mclk);
          HOST.wr(ADDR_SLIP, 8'h01);
        end
        while (k < 3 && n < 40) begin
          @(posedge mclk);
          #1;
          n++;
          if (div_tick === 1'b1) k++;
        end
      join
      chk(16'(n), 16'h000B);
    end
    $display("t_slip done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Verdict and run control
  task automatic wrap_up;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      wrap_up;
    end
  end

  initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    #1;
    t_reset;
    t_pins;
    t_fields;
    t_soft;
    t_ddr;
    t_pattern;
    t_slip;
    wrap_up;
  end
endmodule
`default_nettype wire
